//--- pcr_far_model.sv
`timescale 1ns/100ps
`default_nettype none

// Remote partner: link state and back-channel frames
module pcr_far_model (
   input  wire logic       hclk,
   output logic            link_detected,
   output logic            caps_rx_valid,
   output logic      [5:0] caps_rx_data,
   output logic            ident_rx_valid,
   output logic      [6:0] ident_rx_data
);
   initial begin
      link_detected = 1'b0;
      caps_rx_valid = 1'b0;
      caps_rx_data = 6'h00;
      ident_rx_valid = 1'b0;
      ident_rx_data = 7'h00;
   end
   // Extra edges cover the two sync flops
   task automatic set_link(input logic v);
      @(posedge hclk);
      link_detected <= v;
      repeat (3) @(posedge hclk);
   endtask
   // one-cycle caps frame
   // Idle data is inverted so stale values never look valid
   task automatic send_caps(input logic [5:0] d);
      @(posedge hclk);
      caps_rx_valid <= 1'b1;
      caps_rx_data <= d;
      @(posedge hclk);
      caps_rx_valid <= 1'b0;
      caps_rx_data <= ~d;
      @(posedge hclk);
   endtask
   task automatic send_ident(input logic [6:0] d);
      @(posedge hclk);
      ident_rx_valid <= 1'b1;
      ident_rx_data <= d;
      @(posedge hclk);
      ident_rx_valid <= 1'b0;
      ident_rx_data <= ~d;
      @(posedge hclk);
   endtask
endmodule

`default_nettype wire

//--- pcr_pkg.sv
package pcr_pkg;

   // ---------------------------------------------------------------
   // Register indices (printed offsets; byte address is index * 4)
   // ---------------------------------------------------------------
   localparam logic [7:0] PCR_IDX_CAPS   = 8'h35;  // Partner capabilities
   localparam logic [7:0] PCR_IDX_IDENT  = 8'h37;  // Partner identifier
   localparam logic [7:0] PCR_IDX_SLOT0  = 8'h39;  // Target slot 0
   localparam logic [7:0] PCR_IDX_SLOT1  = 8'h3A;  // Target slot 1
   localparam logic [7:0] PCR_IDX_SLOT2  = 8'h3B;  // Target slot 2
   localparam logic [7:0] PCR_IDX_CAPSRC = 8'h1E;  // Software caps source
   localparam logic [7:0] PCR_IDX_STAT   = 8'h50;  // Block status

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int PCR_CAP_HOLD_BIT   = 7;  // Hold partner caps
   localparam int PCR_CAP_SELFT_BIT  = 5;  // Self-test request
   localparam int PCR_CAP_PARTNER_MULTIPORT_BIT  = 4;  // Multi-port partner
   localparam int PCR_CAP_PORT_MSB   = 3;  // Port index msb
   localparam int PCR_ID_HOLD_BIT    = 0;  // Hold identifier

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] PCR_CAPS_RST  = 8'h00;
   localparam logic [6:0] PCR_IDENT_RST = 7'h00;  // Arbitrary neutral value
   localparam logic [6:0] PCR_SLOT_RST  = 7'h00;

   localparam int PCR_NUM_SLOTS = 3;

endpackage

//--- pcr_regs.sv
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pcr_regs
   import pcr_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        link_detected,
   input  wire logic        caps_rx_valid,
   input  wire logic [5:0]  caps_rx_data,
   input  wire logic        ident_rx_valid,
   input  wire logic [6:0]  ident_rx_data,
   input  wire logic [1:0]  alias_slot,
   input  wire logic        alias_hit,
   input  wire logic [6:0]  i2c_addr_in,
   output logic      [6:0]  i2c_addr_out,
   output logic             partner_selftest_request,
   output logic             partner_multiport,
   output logic      [3:0]  partner_port_index,
   output logic      [6:0]  partner_identifier
);

   // ---------------------------------------------------------------
   // Link detect synchroniser (pin from outside this domain)
   // ---------------------------------------------------------------
   logic link_meta_reg;   // First stage, read only by second
   logic link_sync_reg;   // Safe link-detect level

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         link_meta_reg <= 1'b0;
         link_sync_reg <= 1'b0;
      end else begin
         link_meta_reg <= link_detected;
         link_sync_reg <= link_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // AHB-Lite address phase capture
   // ---------------------------------------------------------------
   logic       wr_pend_reg;   // Write data phase pending
   logic       wr_pend_next;
   logic [7:0] wr_idx_reg;    // Register index of pending write
   logic [7:0] wr_idx_next;
   logic       rd_ok_reg;     // Read data phase in progress
   logic       rd_ok_next;
   logic [31:0] hrdata_reg;   // Registered read data
   logic [31:0] hrdata_next;
   logic       xfer;          // Valid transfer this cycle
   logic [7:0] a_idx;         // Index decoded from address

   // Zero-wait slave: every phase completes in one cycle
   // Limitation: read data is captured in the address phase, so a read
   // placed straight behind a write to the same register returns the
   // old value; software leaves one idle cycle between the two
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;
   assign xfer      = hsel && hready && htrans[1];
   assign a_idx     = haddr[9:2];

   // ---------------------------------------------------------------
   // Register state
   // ---------------------------------------------------------------
   logic [7:0] caps_reg;      // Hold, reserved, self-test, partner_multiport, port
   logic [7:0] caps_next;
   logic [5:0] caps_sw_reg;   // Software-written caps source
   logic [5:0] caps_sw_next;
   logic [6:0] ident_reg;     // Partner identifier
   logic [6:0] ident_next;
   logic       id_hold_reg;   // Identifier hold
   logic       id_hold_next;
   logic [7*PCR_NUM_SLOTS-1:0] slot_reg;   // Packed target slots
   logic [7*PCR_NUM_SLOTS-1:0] slot_next;

   // Read mux for one index
   function automatic logic [7:0] rd_mux(input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         PCR_IDX_CAPS:   v = caps_reg;
         PCR_IDX_IDENT:  v = {ident_reg, id_hold_reg};
         PCR_IDX_SLOT0:  v = {slot_reg[6:0], 1'b0};
         PCR_IDX_SLOT1:  v = {slot_reg[13:7], 1'b0};
         PCR_IDX_SLOT2:  v = {slot_reg[20:14], 1'b0};
         PCR_IDX_CAPSRC: v = {2'b00, caps_sw_reg};
         PCR_IDX_STAT:   v = {7'h00, link_sync_reg};
         default:        v = 8'h00;
      endcase
      return v;
   endfunction

   // Next-state for bus and registers
   always_comb begin
      wr_pend_next = xfer && hwrite;
      wr_idx_next  = xfer ? a_idx : wr_idx_reg;
      rd_ok_next   = xfer && !hwrite;
      hrdata_next  = hrdata_reg;
      caps_next    = caps_reg;
      caps_sw_next = caps_sw_reg;
      ident_next   = ident_reg;
      id_hold_next = id_hold_reg;
      slot_next    = slot_reg;
      // Read data registered at address phase, stands in data phase
      if (xfer && !hwrite) begin
         hrdata_next = {24'h00_0000, rd_mux(a_idx)};
      end
      // Back channel loads first; software write below overrides
      // Link-gated auto-load
      if (link_sync_reg && caps_rx_valid && !caps_reg[PCR_CAP_HOLD_BIT]) begin
         caps_next[5:0] = caps_rx_data;
      end
      if (caps_reg[PCR_CAP_HOLD_BIT]) begin
         caps_next[5:0] = caps_sw_reg;
      end
      if (link_sync_reg && ident_rx_valid && !id_hold_reg) begin
         ident_next = ident_rx_data;
      end
      if (wr_pend_reg) begin
         unique case (wr_idx_reg)
            PCR_IDX_CAPS: begin
               caps_next = hwdata[7:0];
               caps_sw_next = hwdata[5:0];
            end
            PCR_IDX_CAPSRC: caps_sw_next = hwdata[5:0];
            PCR_IDX_IDENT: begin
               ident_next   = hwdata[7:1];
               id_hold_next = hwdata[PCR_ID_HOLD_BIT];
            end
            PCR_IDX_SLOT0: slot_next[6:0]   = hwdata[7:1];
            PCR_IDX_SLOT1: slot_next[13:7]  = hwdata[7:1];
            PCR_IDX_SLOT2: slot_next[20:14] = hwdata[7:1];
            default: ;
         endcase
      end
   end

   // Register update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 8'h00;
         rd_ok_reg   <= 1'b0;
         hrdata_reg  <= 32'h0000_0000;
         caps_reg    <= PCR_CAPS_RST;
         caps_sw_reg <= 6'h00;
         ident_reg   <= PCR_IDENT_RST;
         id_hold_reg <= 1'b0;
         slot_reg    <= {PCR_NUM_SLOTS{PCR_SLOT_RST}};
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_idx_reg  <= wr_idx_next;
         rd_ok_reg   <= rd_ok_next;
         hrdata_reg  <= hrdata_next;
         caps_reg    <= caps_next;
         caps_sw_reg <= caps_sw_next;
         ident_reg   <= ident_next;
         id_hold_reg <= id_hold_next;
         slot_reg    <= slot_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   // Self-test request shown
   assign partner_selftest_request = caps_reg[PCR_CAP_SELFT_BIT];
   assign partner_multiport        = caps_reg[PCR_CAP_PARTNER_MULTIPORT_BIT];
   assign partner_port_index       = caps_reg[PCR_CAP_PORT_MSB:0];
   assign partner_identifier       = ident_reg;

   // Remapper for alias-addressed transactions
   pcr_remap #(
      .NSLOT(PCR_NUM_SLOTS)
   ) u_remap (
      .slot_addrs  (slot_reg),
      .alias_slot  (alias_slot),
      .alias_hit   (alias_hit),
      .i2c_addr_in (i2c_addr_in),
      .i2c_addr_out(i2c_addr_out)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Software writes and frames that may legally move the checked registers
   logic caps_sw_write;   // Write to caps or its source pending
   logic slot_write;      // Write to any target slot pending
   logic caps_rx_live;    // Frame that the capability field must take

   assign caps_sw_write = wr_pend_reg
                          && (wr_idx_reg == PCR_IDX_CAPS || wr_idx_reg == PCR_IDX_CAPSRC);
   assign slot_write    = wr_pend_reg
                          && (wr_idx_reg inside {PCR_IDX_SLOT0, PCR_IDX_SLOT1, PCR_IDX_SLOT2});
   assign caps_rx_live  = link_sync_reg && caps_rx_valid
                          && !caps_reg[PCR_CAP_HOLD_BIT] && !wr_pend_reg;

   a_caps_hold_blocks: assert property (@(posedge hclk) disable iff (!hresetn)
      (caps_reg[PCR_CAP_HOLD_BIT] && !caps_sw_write)
      |=> caps_reg[5:0] == $past(caps_sw_reg))
      else $error("caps changed while held");

   a_caps_src_write: assert property (@(posedge hclk) disable iff (!hresetn)
      caps_sw_write
      |=> caps_sw_reg == $past(hwdata[5:0]))
      else $error("caps source write lost");

   a_caps_auto_load: assert property (@(posedge hclk) disable iff (!hresetn)
      caps_rx_live
      |=> caps_reg[5:0] == $past(caps_rx_data))
      else $error("caps not loaded");

   a_caps_no_link: assert property (@(posedge hclk) disable iff (!hresetn)
      (!caps_reg[PCR_CAP_HOLD_BIT] && !(link_sync_reg && caps_rx_valid) && !wr_pend_reg)
      |=> $stable(caps_reg[5:0]))
      else $error("caps moved without a frame");

   a_caps_drop_held: assert property (@(posedge hclk) disable iff (!hresetn)
      (caps_reg[PCR_CAP_HOLD_BIT] && link_sync_reg && caps_rx_valid && !caps_sw_write)
      |=> caps_reg[5:0] == $past(caps_sw_reg))
      else $error("frame taken while held");

   a_selftest_out: assert property (@(posedge hclk) disable iff (!hresetn)
      caps_rx_live
      |=> partner_selftest_request == $past(caps_rx_data[PCR_CAP_SELFT_BIT]))
      else $error("self-test request wrong");

   a_multiport_out: assert property (@(posedge hclk) disable iff (!hresetn)
      caps_rx_live
      |=> partner_multiport == $past(caps_rx_data[PCR_CAP_PARTNER_MULTIPORT_BIT]))
      else $error("partner type wrong");

   a_port_out: assert property (@(posedge hclk) disable iff (!hresetn)
      caps_rx_live
      |=> partner_port_index == $past(caps_rx_data[PCR_CAP_PORT_MSB:0]))
      else $error("port index wrong");

   a_ident_load: assert property (@(posedge hclk) disable iff (!hresetn)
      (link_sync_reg && ident_rx_valid && !id_hold_reg && !wr_pend_reg)
      |=> partner_identifier == $past(ident_rx_data))
      else $error("identifier not loaded");

   a_ident_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      (id_hold_reg && !wr_pend_reg)
      |=> $stable(ident_reg))
      else $error("identifier changed while held");

   a_ident_write: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_idx_reg == PCR_IDX_IDENT)
      |=> {ident_reg, id_hold_reg} == $past(hwdata[7:0]))
      else $error("identifier write lost");

   a_remap_slot: assert property (@(posedge hclk) disable iff (!hresetn)
      (alias_hit && alias_slot == 2'd1)
      |-> i2c_addr_out == slot_reg[13:7])
      else $error("remap wrong");

   a_remap_miss: assert property (@(posedge hclk) disable iff (!hresetn)
      !alias_hit
      |-> i2c_addr_out == i2c_addr_in)
      else $error("address changed without a hit");

   a_slot_write: assert property (@(posedge hclk) disable iff (!hresetn)
      (wr_pend_reg && wr_idx_reg == PCR_IDX_SLOT0)
      |=> slot_reg[6:0] == $past(hwdata[7:1]))
      else $error("slot write lost");

   a_slot_stable: assert property (@(posedge hclk) disable iff (!hresetn)
      !slot_write
      |=> $stable(slot_reg))
      else $error("slot changed without a write");

   a_read_slot: assert property (@(posedge hclk) disable iff (!hresetn)
      (xfer && !hwrite && a_idx == PCR_IDX_SLOT1)
      |=> rd_ok_reg && hrdata == {24'h00_0000, $past(slot_reg[13:7]), 1'b0})
      else $error("slot read wrong");

endmodule

`default_nettype wire

//--- pcr_remap.sv
`timescale 1ns/100ps
`default_nettype none

// Alias-to-target remapper: pure lookup, no state
module pcr_remap
   import pcr_pkg::*;
#(
   parameter int NSLOT = PCR_NUM_SLOTS
) (
   input  wire logic [7*NSLOT-1:0] slot_addrs,
   input  wire logic [1:0]         alias_slot,
   input  wire logic               alias_hit,
   input  wire logic [6:0]         i2c_addr_in,
   output logic      [6:0]         i2c_addr_out
);

   // Slot select is two bits wide, so no more than four slots fit
   if (NSLOT < 1 || NSLOT > 4) begin
      $error("pcr_remap: NSLOT must lie between 1 and 4");
   end

   // ---------------------------------------------------------------
   // Address replacement
   // ---------------------------------------------------------------
   // alias swaps address
   always_comb begin
      i2c_addr_out = i2c_addr_in;
      if (alias_hit && (int'(alias_slot) < NSLOT)) begin
         i2c_addr_out = slot_addrs[7*alias_slot +: 7];
      end
   end

endmodule

`default_nettype wire

//--- test_partner_caps_target_remap_regs.sv
`timescale 1ns/100ps
`default_nettype none

module test_partner_caps_target_remap_regs;
   import pcr_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hrdy, hresp, lnk, cv, iv, a_hit;
   logic [11:0] haddr;
   logic [1:0] htrans, a_slot;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rdv;
   logic [5:0] cd;
   logic [6:0] idd, a_in, a_out, p_id;
   logic p_st, p_mp;
   logic [3:0] p_port;
   int n_errors, samples_checked, cyc;

   pcr_far_model i_far (.hclk(hclk), .link_detected(lnk), .caps_rx_valid(cv),
      .caps_rx_data(cd), .ident_rx_valid(iv), .ident_rx_data(idd));
   pcr_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
      .link_detected(lnk), .caps_rx_valid(cv), .caps_rx_data(cd),
      .ident_rx_valid(iv), .ident_rx_data(idd), .alias_slot(a_slot),
      .alias_hit(a_hit), .i2c_addr_in(a_in), .i2c_addr_out(a_out),
      .partner_selftest_request(p_st), .partner_multiport(p_mp),
      .partner_port_index(p_port), .partner_identifier(p_id));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Generous ceiling: the tests need well under 1000 cycles
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         wrap_up();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Single AHB-Lite word transfer, waits on hready in both phases
   task automatic ahb(input logic w, input logic [7:0] i, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {2'b00, i, 2'b00};
      do @(posedge hclk); while (hrdy !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hrdy !== 1'b1);
      rdv = hrdata;
      hsel <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] exp);
      ahb(1'b0, i, 32'h0000_0000);
      check(rdv, exp);
      check({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask
   // Remap inputs change on the edge, output judged mid-cycle
   task automatic remap(input logic h, input logic [1:0] s, input logic [6:0] ain,
                        input logic [6:0] e);
      @(posedge hclk);
      a_hit <= h;
      a_slot <= s;
      a_in <= ain;
      @(negedge hclk);
      check({25'h0, a_out}, {25'h0, e});
   endtask

   task automatic t_reset();
      rd(PCR_IDX_CAPS, 32'h0000_0000);
      rd(PCR_IDX_IDENT, 32'h0000_0000);
      for (int n = 0; n < 3; n++) rd(8'(PCR_IDX_SLOT0 + n), 32'h0000_0000);
      check({19'h0_0000, p_st, p_mp, p_port, p_id}, 32'h0000_0000);
      $display("t_reset done");
   endtask
   task automatic t_slots();
      ahb(1'b1, PCR_IDX_SLOT0, 32'h0000_00FF);
      ahb(1'b1, PCR_IDX_SLOT1, 32'h0000_005A);
      ahb(1'b1, PCR_IDX_SLOT2, 32'h0000_0081);
      ahb(1'b1, 8'h3C, 32'h0000_00FF);
      rd(PCR_IDX_SLOT0, 32'h0000_00FE);
      rd(PCR_IDX_SLOT1, 32'h0000_005A);
      rd(PCR_IDX_SLOT2, 32'h0000_0080);
      rd(8'h3C, 32'h0000_0000);
      remap(1'b1, 2'd0, 7'h11, 7'h7F);
      remap(1'b1, 2'd1, 7'h22, 7'h2D);
      remap(1'b1, 2'd2, 7'h33, 7'h40);
      remap(1'b0, 2'd2, 7'h44, 7'h44);
      $display("t_slots done");
   endtask
   task automatic t_link();
      i_far.send_caps(6'h3A);
      rd(PCR_IDX_CAPS, 32'h0000_0000);
      i_far.set_link(1'b1);
      rd(PCR_IDX_STAT, 32'h0000_0001);
      i_far.send_caps(6'h3A);
      rd(PCR_IDX_CAPS, 32'h0000_003A);
      check({26'h000_0000, p_st, p_mp, p_port}, 32'h0000_003A);
      i_far.send_caps(6'h05);
      check({27'h000_0000, p_mp, p_port}, 32'h0000_0005);
      $display("t_link done");
   endtask
   task automatic t_hold_caps();
      // software value goes in with hold set
      ahb(1'b1, PCR_IDX_CAPS, 32'h0000_0096);
      i_far.send_caps(6'h29);
      rd(PCR_IDX_CAPS, 32'h0000_0096);
      rd(PCR_IDX_CAPSRC, 32'h0000_0016);
      check({26'h000_0000, p_st, p_mp, p_port}, 32'h0000_0016);
      // source rewritten while hold stays set
      ahb(1'b1, PCR_IDX_CAPSRC, 32'h0000_002B);
      rd(PCR_IDX_CAPS, 32'h0000_00AB);
      ahb(1'b1, PCR_IDX_CAPS, 32'h0000_0000);
      i_far.send_caps(6'h29);
      rd(PCR_IDX_CAPS, 32'h0000_0029);
      $display("t_hold_caps done");
   endtask
   task automatic t_ident();
      i_far.send_ident(7'h55);
      rd(PCR_IDX_IDENT, 32'h0000_00AA);
      ahb(1'b1, PCR_IDX_IDENT, 32'h0000_0047);
      i_far.send_ident(7'h11);
      check({25'h0, p_id}, 32'h0000_0023);
      ahb(1'b1, PCR_IDX_IDENT, 32'h0000_0046);
      i_far.send_ident(7'h11);
      rd(PCR_IDX_IDENT, 32'h0000_0022);
      $display("t_ident done");
   endtask

   // Reset in mid-run clears registers and the link synchroniser
   task automatic t_midreset();
      ahb(1'b1, PCR_IDX_SLOT1, 32'h0000_0066);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(PCR_IDX_SLOT1, 32'h0000_0000);
      rd(PCR_IDX_IDENT, 32'h0000_0000);
      rd(PCR_IDX_CAPS, 32'h0000_0000);
      check({19'h0_0000, p_st, p_mp, p_port, p_id}, 32'h0000_0000);
      rd(PCR_IDX_STAT, 32'h0000_0001);
      i_far.send_caps(6'h15);
      rd(PCR_IDX_CAPS, 32'h0000_0015);
      $display("t_midreset done");
   endtask

   task automatic wrap_up();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      {n_errors, samples_checked, cyc} = '0;
      {hresetn, hsel, hwrite, a_hit, htrans, a_slot} = '0;
      haddr = 12'h000;
      hsize = 3'b010;
      hwdata = 32'h0000_0000;
      a_in = 7'h00;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_slots();
      t_link();
      t_hold_caps();
      t_ident();
      t_midreset();
      wrap_up();
   end
endmodule

`default_nettype wire
